// ==== inc/bvf_consts.svh ====
`ifndef BVF_CONSTS_SVH
`define BVF_CONSTS_SVH

// Register offsets on the serial register port
`define BVF_ADDR_W          8
`define BVF_ADDR_GD_STATUS  8'he0
`define BVF_ADDR_CTRL_STAT  8'he2
`define BVF_ADDR_SUPPLY_CFG 8'h92

// Supply fault configuration field positions
`define BVF_CFG_W           12
`define BVF_CFG_RESET       12'h000
`define BVF_CFG_HYS_BIT     11
`define BVF_CFG_UV_THR_HI   10
`define BVF_CFG_UV_THR_LO   8
`define BVF_CFG_UV_MODE_BIT 7
`define BVF_CFG_OV_THR_HI   6
`define BVF_CFG_OV_THR_LO   4
`define BVF_CFG_OV_MODE_BIT 3
`define BVF_CFG_RETRY_HI    2
`define BVF_CFG_RETRY_LO    0

// Power-stage status word bit positions
`define BVF_GD_SUMMARY_BIT  31
`define BVF_GD_OTEMP_BIT    29
`define BVF_GD_VDS_OC_BIT   28
`define BVF_GD_SNS_OC_BIT   27
`define BVF_GD_BST_UV_BIT   26
`define BVF_GD_GSUP_UV_BIT  25
`define BVF_GD_DRIVER_SHUTDOWN_FLAG_BIT  24

// Controller status word bit positions
`define BVF_CS_SUMMARY_BIT  31
`define BVF_CS_UV_BIT       17
`define BVF_CS_OV_BIT       16

// Supply voltage measured in units of 0.1 V
`define BVF_VOLT_W          10
`define BVF_UV_HYS_LO_DV    10'h005
`define BVF_UV_HYS_HI_DV    10'h00a
`define BVF_OV_HYS_LO_DV    10'h00a
`define BVF_OV_HYS_HI_DV    10'h014

// Timing
`define BVF_CLK_KHZ         25000
`define BVF_RETRY_WAIT_MS   100
`define BVF_RETRY_CNT_W     5
`define BVF_WAIT_CNT_W      32

`endif

// ==== inc/bvf_pkg.sv ====
`include "bvf_consts.svh"

package bvf_pkg;

    typedef enum logic [1:0] {
        BVF_RETRY_IDLE,
        BVF_RETRY_ACTIVE,
        BVF_RETRY_LATCHED
    } bvf_retry_e;

    typedef logic [`BVF_VOLT_W-1:0] bvf_volt_t;

    typedef struct packed {
        logic [`BVF_CFG_W-1:0]       cfg;
        logic [5:0]                  drv_flags;
        logic                        uv_flag;
        logic                        ov_flag;
        bvf_retry_e                  rstate;
        logic [`BVF_WAIT_CNT_W-1:0]  wait_cnt;
        logic [`BVF_RETRY_CNT_W-1:0] retry_cnt;
        logic                        retry_flag;
        logic                        retry_latched;
        logic [31:0]                 rdata;
    } bvf_state_s;

    // Undervoltage limit in 0.1 V, zero means no limit
    function automatic bvf_volt_t bvf_uv_limit(input logic [2:0] code);
        case (code)
            3'h1:    bvf_uv_limit = 10'h032;
            3'h2:    bvf_uv_limit = 10'h03c;
            3'h3:    bvf_uv_limit = 10'h046;
            3'h4:    bvf_uv_limit = 10'h050;
            3'h5:    bvf_uv_limit = 10'h064;
            3'h6:    bvf_uv_limit = 10'h078;
            3'h7:    bvf_uv_limit = 10'h096;
            default: bvf_uv_limit = 10'h000;
        endcase
    endfunction : bvf_uv_limit

    // Overvoltage limit in 0.1 V, zero means no limit
    function automatic bvf_volt_t bvf_ov_limit(input logic [2:0] code);
        case (code)
            3'h1:    bvf_ov_limit = 10'h064;
            3'h2:    bvf_ov_limit = 10'h096;
            3'h3:    bvf_ov_limit = 10'h0dc;
            3'h4:    bvf_ov_limit = 10'h140;
            3'h5:    bvf_ov_limit = 10'h190;
            3'h6:    bvf_ov_limit = 10'h1f4;
            3'h7:    bvf_ov_limit = 10'h258;
            default: bvf_ov_limit = 10'h000;
        endcase
    endfunction : bvf_ov_limit

    // Allowed retry attempts, zero means unlimited
    function automatic logic [`BVF_RETRY_CNT_W-1:0] bvf_retry_max(input logic [2:0] code);
        case (code)
            3'h1:    bvf_retry_max = 5'h02;
            3'h2:    bvf_retry_max = 5'h03;
            3'h3:    bvf_retry_max = 5'h05;
            3'h4:    bvf_retry_max = 5'h07;
            3'h5:    bvf_retry_max = 5'h0a;
            3'h6:    bvf_retry_max = 5'h0f;
            3'h7:    bvf_retry_max = 5'h14;
            default: bvf_retry_max = 5'h00;
        endcase
    endfunction : bvf_retry_max

endpackage : bvf_pkg

// ==== design/bvf_fault_bank.sv ====
`timescale 1ns/100ps
`include "bvf_consts.svh"

// What this block does
// - Hysteresis bit picks 0.5V/1V or 1V/2V recovery margins for undervoltage/overvoltage.
// - Undervoltage threshold code 0 is no limit, 1..7 map 5 to 15 volts.
// - Undervoltage mode 0 latches the fault, 1 clears it once voltage recovers.
// - Overvoltage threshold code 0 is no limit, 1..7 map 10 to 60 volts.
// - Overvoltage mode 0 latches the fault, 1 clears it once voltage recovers.
// - Retry limit code 0 unlimited, 1..7 allow 2,3,5,7,10,15,20 attempts.
// - Power-stage bit 31 is the OR of the driver fault flags.
// - Power-stage bit 29 shows over-temperature warning or shutdown.
// - Power-stage bit 28 shows drain-source overcurrent.
// - Power-stage bit 27 shows shunt path overcurrent.
// - Power-stage bit 26 shows bootstrap supply undervoltage.
// - Power-stage bit 25 shows gate-drive supply undervoltage.
// - Power-stage bit 24 shows the independent driver shutdown state.
// - Power-stage word at E0h, controller word at E2h, configuration at 92h, others reserved.
// - Retry faults clear after the wait time, latch once retries exceed limit.
// - Controller word bit 17 reports supply undervoltage fault.
// - Controller word bit 16 reports supply overvoltage fault.
module bvf_fault_bank #(
    parameter int unsigned RETRY_WAIT_CYCLES = `BVF_RETRY_WAIT_MS * `BVF_CLK_KHZ
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic [`BVF_ADDR_W-1:0] reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    input  wire logic [`BVF_VOLT_W-1:0] motor_supply,
    input  wire logic                   fault_clear,
    input  wire logic                   retry_fault_in,
    input  wire logic                   over_temperature_in,
    input  wire logic                   drain_source_overcurrent_in,
    input  wire logic                   shunt_overcurrent_in,
    input  wire logic                   bootstrap_undervoltage_in,
    input  wire logic                   gate_supply_undervoltage_in,
    input  wire logic                   driver_shutdown_input,
    output logic                        bus_undervoltage_flag,
    output logic                        bus_overvoltage_flag,
    output logic                        retry_fault_flag,
    output logic                        retry_fault_latched
);

    // Wait counter holds 32 bits; a zero wait would wrap to the longest possible wait
    if (RETRY_WAIT_CYCLES < 1) begin : g_bad_wait
        $error("RETRY_WAIT_CYCLES must be at least one");
    end

    localparam logic [`BVF_WAIT_CNT_W-1:0] WAIT_LAST = `BVF_WAIT_CNT_W'(RETRY_WAIT_CYCLES - 1);

    bvf_pkg::bvf_state_s st_reg;
    bvf_pkg::bvf_state_s st_next;

    logic [2:0]        uv_code;
    logic [2:0]        ov_code;
    bvf_pkg::bvf_volt_t uv_lim;
    bvf_pkg::bvf_volt_t ov_lim;
    bvf_pkg::bvf_volt_t uv_hys;
    bvf_pkg::bvf_volt_t ov_hys;
    logic [`BVF_VOLT_W:0] uv_release;
    logic [`BVF_VOLT_W:0] ov_release;
    logic              uv_detect;
    logic              ov_detect;
    logic [4:0]        rmax;
    logic [31:0]       gd_word;
    logic [31:0]       cs_word;

    // Field decode of the configuration word
    assign uv_code = st_reg.cfg[`BVF_CFG_UV_THR_HI:`BVF_CFG_UV_THR_LO];
    assign ov_code = st_reg.cfg[`BVF_CFG_OV_THR_HI:`BVF_CFG_OV_THR_LO];
    assign uv_lim  = bvf_pkg::bvf_uv_limit(uv_code);
    assign ov_lim  = bvf_pkg::bvf_ov_limit(ov_code);
    assign rmax    = bvf_pkg::bvf_retry_max(
        st_reg.cfg[`BVF_CFG_RETRY_HI:`BVF_CFG_RETRY_LO]);

    // Recovery margins chosen by the hysteresis bit
    assign uv_hys = st_reg.cfg[`BVF_CFG_HYS_BIT] ? `BVF_UV_HYS_HI_DV : `BVF_UV_HYS_LO_DV;
    assign ov_hys = st_reg.cfg[`BVF_CFG_HYS_BIT] ? `BVF_OV_HYS_HI_DV : `BVF_OV_HYS_LO_DV;

    // One spare bit so threshold plus margin cannot wrap
    assign uv_release = {1'b0, uv_lim} + {1'b0, uv_hys};
    assign ov_release = {1'b0, ov_lim} - {1'b0, ov_hys};

    // A zero code disables detection entirely
    assign uv_detect = (uv_code != 3'h0) && (motor_supply < uv_lim);
    assign ov_detect = (ov_code != 3'h0) && (motor_supply > ov_lim);

    // Status words built from stored flags, reserved bits tied low
    always_comb begin
        gd_word = 32'h0000_0000;
        gd_word[`BVF_GD_OTEMP_BIT]   = st_reg.drv_flags[5];
        gd_word[`BVF_GD_VDS_OC_BIT]  = st_reg.drv_flags[4];
        gd_word[`BVF_GD_SNS_OC_BIT]  = st_reg.drv_flags[3];
        gd_word[`BVF_GD_BST_UV_BIT]  = st_reg.drv_flags[2];
        gd_word[`BVF_GD_GSUP_UV_BIT] = st_reg.drv_flags[1];
        gd_word[`BVF_GD_DRIVER_SHUTDOWN_FLAG_BIT] = st_reg.drv_flags[0];
        gd_word[`BVF_GD_SUMMARY_BIT] = |st_reg.drv_flags;
        cs_word = 32'h0000_0000;
        cs_word[`BVF_CS_UV_BIT]      = st_reg.uv_flag;
        cs_word[`BVF_CS_OV_BIT]      = st_reg.ov_flag;
        cs_word[`BVF_CS_SUMMARY_BIT] = st_reg.uv_flag | st_reg.ov_flag;
    end

    // Whole next state in one place
    always_comb begin
        st_next = st_reg;

        // Driver flags track the detector levels, one cycle late
        st_next.drv_flags = {over_temperature_in, drain_source_overcurrent_in,
                             shunt_overcurrent_in, bootstrap_undervoltage_in,
                             gate_supply_undervoltage_in, driver_shutdown_input};

        // Only the configuration word takes writes; status writes fall away
        if (reg_wr && (reg_addr == `BVF_ADDR_SUPPLY_CFG)) begin
            st_next.cfg = reg_wdata[`BVF_CFG_W-1:0];
        end

        // Undervoltage: detection wins over any clear in the same cycle
        if (uv_detect) begin
            st_next.uv_flag = 1'b1;
        end else if (st_reg.uv_flag) begin
            if (st_reg.cfg[`BVF_CFG_UV_MODE_BIT]) begin
                if ({1'b0, motor_supply} > uv_release || uv_code == 3'h0) begin
                    st_next.uv_flag = 1'b0;
                end
            end else if (fault_clear) begin
                st_next.uv_flag = 1'b0;
            end
        end

        // Overvoltage mirrors the undervoltage handling
        if (ov_detect) begin
            st_next.ov_flag = 1'b1;
        end else if (st_reg.ov_flag) begin
            if (st_reg.cfg[`BVF_CFG_OV_MODE_BIT]) begin
                if ({1'b0, motor_supply} < ov_release || ov_code == 3'h0) begin
                    st_next.ov_flag = 1'b0;
                end
            end else if (fault_clear) begin
                st_next.ov_flag = 1'b0;
            end
        end

        // Retry engine for faults configured to retry
        case (st_reg.rstate)
            bvf_pkg::BVF_RETRY_IDLE: begin
                if (retry_fault_in) begin
                    st_next.retry_flag = 1'b1;
                    st_next.wait_cnt   = '0;
                    if (rmax != 5'h00 && st_reg.retry_cnt >= rmax) begin
                        st_next.rstate = bvf_pkg::BVF_RETRY_LATCHED;
                    end else begin
                        st_next.rstate = bvf_pkg::BVF_RETRY_ACTIVE;
                    end
                end else if (fault_clear) begin
                    st_next.retry_cnt = '0;
                end
            end
            bvf_pkg::BVF_RETRY_ACTIVE: begin
                if (st_reg.wait_cnt == WAIT_LAST) begin
                    st_next.retry_flag = 1'b0;
                    st_next.rstate     = bvf_pkg::BVF_RETRY_IDLE;
                    if (st_reg.retry_cnt != 5'h1f) begin
                        st_next.retry_cnt = st_reg.retry_cnt + 5'h01;
                    end
                end else begin
                    st_next.wait_cnt = st_reg.wait_cnt + `BVF_WAIT_CNT_W'(1);
                end
            end
            bvf_pkg::BVF_RETRY_LATCHED: begin
                // A still-present fault keeps it latched
                if (fault_clear && !retry_fault_in) begin
                    st_next.retry_flag = 1'b0;
                    st_next.retry_cnt  = '0;
                    st_next.rstate     = bvf_pkg::BVF_RETRY_IDLE;
                end
            end
            default: begin
                st_next.rstate = bvf_pkg::BVF_RETRY_IDLE;
            end
        endcase

        // Registered copy so the latched output comes straight from a flop
        st_next.retry_latched = (st_next.rstate == bvf_pkg::BVF_RETRY_LATCHED);

        // Read data held until the next read; unmapped offsets give zero
        if (reg_rd) begin
            if (reg_addr == `BVF_ADDR_GD_STATUS) begin
                st_next.rdata = gd_word;
            end else if (reg_addr == `BVF_ADDR_CTRL_STAT) begin
                st_next.rdata = cs_word;
            end else if (reg_addr == `BVF_ADDR_SUPPLY_CFG) begin
                st_next.rdata = {20'h00000, st_reg.cfg};
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{cfg: `BVF_CFG_RESET, drv_flags: 6'h00, uv_flag: 1'b0,
                        ov_flag: 1'b0, rstate: bvf_pkg::BVF_RETRY_IDLE,
                        wait_cnt: '0, retry_cnt: '0, retry_flag: 1'b0, retry_latched: 1'b0,
                        rdata: 32'h0000_0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata             = st_reg.rdata;
    assign bus_undervoltage_flag = st_reg.uv_flag;
    assign bus_overvoltage_flag  = st_reg.ov_flag;
    assign retry_fault_flag      = st_reg.retry_flag;
    assign retry_fault_latched   = st_reg.retry_latched;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_gd_summary_or: assert property (
        reg_rd && reg_addr == `BVF_ADDR_GD_STATUS |=> reg_rdata[31] == |reg_rdata[29:24])
        else $error("Driver summary bit does not match flags");

    a_gd_flags_read: assert property (
        reg_rd && reg_addr == `BVF_ADDR_GD_STATUS && !rst
        |=> reg_rdata[29:24] == $past(st_reg.drv_flags) && reg_rdata[23:0] == 24'h000000)
        else $error("Power-stage word read back wrong");

    a_uv_set_below: assert property (
        uv_detect |=> bus_undervoltage_flag)
        else $error("Undervoltage not flagged below limit");

    a_uv_latch_hold: assert property (
        bus_undervoltage_flag && !st_reg.cfg[`BVF_CFG_UV_MODE_BIT] && !fault_clear
        |=> bus_undervoltage_flag)
        else $error("Latched undervoltage cleared itself");

    a_uv_hyst_hold: assert property (
        bus_undervoltage_flag && st_reg.cfg[`BVF_CFG_UV_MODE_BIT] && uv_code != 3'h0
        && {1'b0, motor_supply} <= uv_release
        |=> bus_undervoltage_flag)
        else $error("Undervoltage cleared inside hysteresis");

    a_ov_set_above: assert property (
        ov_detect |=> bus_overvoltage_flag)
        else $error("Overvoltage not flagged above limit");

    a_ov_latch_hold: assert property (
        bus_overvoltage_flag && !st_reg.cfg[`BVF_CFG_OV_MODE_BIT] && !fault_clear
        |=> bus_overvoltage_flag)
        else $error("Latched overvoltage cleared itself");

    a_cs_word_read: assert property (
        reg_rd && reg_addr == `BVF_ADDR_CTRL_STAT
        |=> reg_rdata[17] == $past(bus_undervoltage_flag)
            && reg_rdata[16] == $past(bus_overvoltage_flag) && reg_rdata[15:0] == 16'h0000)
        else $error("Controller word read back wrong");

    a_cfg_write_keep: assert property (
        reg_wr && reg_addr == `BVF_ADDR_SUPPLY_CFG
        |=> st_reg.cfg == $past(reg_wdata[`BVF_CFG_W-1:0]))
        else $error("Configuration write not stored");

    a_retry_timeout: assert property (
        st_reg.rstate == bvf_pkg::BVF_RETRY_ACTIVE && st_reg.wait_cnt == WAIT_LAST
        |=> !retry_fault_flag)
        else $error("Retry fault not cleared after wait");

    a_retry_latch: assert property (
        st_reg.rstate == bvf_pkg::BVF_RETRY_IDLE && retry_fault_in && rmax != 5'h00
        && st_reg.retry_cnt >= rmax |=> retry_fault_latched ##1 retry_fault_flag)
        else $error("Retry limit exceeded without latching");

    a_ov_hyst_hold: assert property (
        bus_overvoltage_flag && st_reg.cfg[`BVF_CFG_OV_MODE_BIT] && ov_code != 3'h0
        && {1'b0, motor_supply} >= ov_release |=> bus_overvoltage_flag)
        else $error("Overvoltage cleared inside hysteresis");

    a_status_no_write: assert property (
        reg_wr && reg_addr != `BVF_ADDR_SUPPLY_CFG |=> $stable(st_reg.cfg))
        else $error("Write to a status offset changed the configuration");

    a_retry_unlimited: assert property (
        st_reg.rstate == bvf_pkg::BVF_RETRY_IDLE && retry_fault_in && rmax == 5'h00
        |=> retry_fault_flag && !retry_fault_latched)
        else $error("Unlimited retry latched a fault");

    a_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("Read data changed without a read");

    c_uv_auto_clear: cover property (
        bus_undervoltage_flag && st_reg.cfg[`BVF_CFG_UV_MODE_BIT] ##1 !bus_undervoltage_flag);
    c_ov_latched: cover property (
        bus_overvoltage_flag && !st_reg.cfg[`BVF_CFG_OV_MODE_BIT] ##3 bus_overvoltage_flag);
    c_retry_latched: cover property (retry_fault_latched);
    c_gd_read_fault: cover property (
        reg_rd && reg_addr == `BVF_ADDR_GD_STATUS ##1 reg_rdata[31]);

endmodule : bvf_fault_bank

// ==== dv/bvf_fault_bank_tb.sv ====
`timescale 1ns/100ps
`include "bvf_consts.svh"

module testbench;
    // Short retry wait keeps the run brief; expectations use the same value
    localparam int WAIT_CYC  = 4;
    localparam int LIMIT_CYC = 20000;
    localparam logic [9:0] UV_LIM [8] = '{10'h000, 10'h032, 10'h03c, 10'h046, 10'h050,
                                          10'h064, 10'h078, 10'h096};
    localparam logic [9:0] OV_LIM [8] = '{10'h000, 10'h064, 10'h096, 10'h0dc, 10'h140,
                                          10'h190, 10'h1f4, 10'h258};
    localparam int RETRY_N [8] = '{21, 2, 3, 5, 7, 10, 15, 20};

    logic        ref_clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [31:0] reg_wdata;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [9:0]  motor_supply;
    logic        fault_clear;
    logic        retry_fault_in;
    logic [5:0]  drv_in;
    logic        bus_undervoltage_flag;
    logic        bus_overvoltage_flag;
    logic        retry_fault_flag;
    logic        retry_fault_latched;
    logic [31:0] rd_val;
    int          failures;
    int          comparisons;
    int          cycles = 0;

    // Detector bits 0..5 land on status bits 24..29
    bvf_fault_bank #(.RETRY_WAIT_CYCLES(WAIT_CYC)) u_dut (
        .ref_clk                     (ref_clk),
        .rst                         (rst),
        .reg_addr                    (reg_addr),
        .reg_wr                      (reg_wr),
        .reg_wdata                   (reg_wdata),
        .reg_rd                      (reg_rd),
        .reg_rdata                   (reg_rdata),
        .motor_supply                (motor_supply),
        .fault_clear                 (fault_clear),
        .retry_fault_in              (retry_fault_in),
        .over_temperature_in         (drv_in[5]),
        .drain_source_overcurrent_in (drv_in[4]),
        .shunt_overcurrent_in        (drv_in[3]),
        .bootstrap_undervoltage_in   (drv_in[2]),
        .gate_supply_undervoltage_in (drv_in[1]),
        .driver_shutdown_input       (drv_in[0]),
        .bus_undervoltage_flag       (bus_undervoltage_flag),
        .bus_overvoltage_flag        (bus_overvoltage_flag),
        .retry_fault_flag            (retry_fault_flag),
        .retry_fault_latched         (retry_fault_latched)
    );

    // Free-running clock, 40 ns period
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Hang guard, far above the expected run length
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT_CYC) begin
            failures++;
            complete_run();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Strobes are dropped then a cycle passes, so back-to-back calls never retoggle
    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        cyc(1);
        reg_wr    = 1'b0;
        cyc(1);
    endtask : reg_write

    task automatic rchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        reg_addr = addr;
        reg_rd   = 1'b1;
        cyc(1);
        reg_rd   = 1'b0;
        chk(what, reg_rdata, exp);
        cyc(1);
    endtask : rchk

    task automatic pulse_clear();
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(1);
    endtask : pulse_clear

    function automatic logic [31:0] sel_flag(input bit is_ov);
        return {31'h0, is_ov ? bus_overvoltage_flag : bus_undervoltage_flag};
    endfunction : sel_flag

    // Auto mode: set just past the limit, hold at the hysteresis edge, release one step beyond
    // Supply left by the previous step is clear of the old and new limits, so no stray latch
    task automatic sweep(input bit is_ov, input logic [2:0] code, input bit hys);
        logic [9:0] lim;
        logic [9:0] m;
        lim = is_ov ? OV_LIM[code] : UV_LIM[code];
        m   = is_ov ? (hys ? 10'h014 : 10'h00a) : (hys ? 10'h00a : 10'h005);
        reg_write(`BVF_ADDR_SUPPLY_CFG, is_ov ? {20'h0, hys, 3'h0, 1'b0, code, 1'b1, 3'h0}
                                              : {20'h0, hys, code, 1'b1, 3'h0, 1'b0, 3'h0});
        motor_supply = lim;
        cyc(2);
        chk("flag at limit", sel_flag(is_ov), 32'h0);
        motor_supply = is_ov ? lim + 10'h001 : lim - 10'h001;
        cyc(2);
        chk("flag past limit", sel_flag(is_ov), 32'h1);
        rchk("ctrl word", `BVF_ADDR_CTRL_STAT, is_ov ? 32'h8001_0000 : 32'h8002_0000);
        motor_supply = is_ov ? lim - m : lim + m;
        cyc(2);
        chk("flag at margin", sel_flag(is_ov), 32'h1);
        motor_supply = is_ov ? lim - m - 10'h001 : lim + m + 10'h001;
        cyc(2);
        chk("flag auto clear", sel_flag(is_ov), 32'h0);
    endtask : sweep

    // Latch mode on code 1: survives recovery and a clear while still faulted
    task automatic latch(input bit is_ov);
        motor_supply = is_ov ? 10'h010 : 10'h100;
        reg_write(`BVF_ADDR_SUPPLY_CFG, is_ov ? 32'h0000_0010 : 32'h0000_0100);
        motor_supply = is_ov ? 10'h200 : 10'h010;
        cyc(2);
        pulse_clear();
        chk("latched set wins", sel_flag(is_ov), 32'h1);
        motor_supply = is_ov ? 10'h010 : 10'h100;
        cyc(3);
        chk("latched holds", sel_flag(is_ov), 32'h1);
        pulse_clear();
        chk("latched cleared", sel_flag(is_ov), 32'h0);
    endtask : latch

    task automatic retry_once(input logic exp_latch);
        retry_fault_in = 1'b1;
        cyc(1);
        retry_fault_in = 1'b0;
        chk("retry flag up", {31'h0, retry_fault_flag}, 32'h1);
        cyc(WAIT_CYC - 1);
        chk("retry flag held", {31'h0, retry_fault_flag}, 32'h1);
        cyc(1);
        chk("retry flag end", {31'h0, retry_fault_flag}, {31'h0, exp_latch});
        chk("retry latched", {31'h0, retry_fault_latched}, {31'h0, exp_latch});
        cyc(1);
    endtask : retry_once

    // Main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 32'h0;
        reg_rd = 1'b0;
        motor_supply = 10'h0c8;
        fault_clear = 1'b0;
        retry_fault_in = 1'b0;
        drv_in = 6'h00;
        cyc(20);
        rst = 1'b0;
        rchk("cfg reset", `BVF_ADDR_SUPPLY_CFG, 32'h0);
        rchk("power word reset", `BVF_ADDR_GD_STATUS, 32'h0);
        rchk("ctrl word reset", `BVF_ADDR_CTRL_STAT, 32'h0);
        reg_write(`BVF_ADDR_SUPPLY_CFG, 32'hffff_ffff);
        rchk("cfg upper bits", `BVF_ADDR_SUPPLY_CFG, 32'h0000_0fff);
        reg_write(`BVF_ADDR_SUPPLY_CFG, 32'h0000_0a5a);
        reg_write(8'h94, 32'hffff_ffff);
        rchk("cfg after stray write", `BVF_ADDR_SUPPLY_CFG, 32'h0000_0a5a);
        rchk("unmapped read", 8'h94, 32'h0);
        reg_write(`BVF_ADDR_SUPPLY_CFG, 32'h0);
        // One detector at a time, then all with a write attempt on the status words
        for (int i = 0; i < 6; i++) begin
            drv_in = 6'h01 << i;
            cyc(2);
            rd_val = 32'h8000_0000 | (32'h0100_0000 << i);
            rchk("power word", `BVF_ADDR_GD_STATUS, rd_val);
        end
        drv_in = 6'h3f;
        reg_write(`BVF_ADDR_GD_STATUS, 32'h0);
        reg_write(`BVF_ADDR_CTRL_STAT, 32'hffff_ffff);
        rchk("power word all", `BVF_ADDR_GD_STATUS, 32'hbf00_0000);
        rchk("ctrl word no write", `BVF_ADDR_CTRL_STAT, 32'h0);
        drv_in = 6'h00;
        cyc(2);
        rchk("power word idle", `BVF_ADDR_GD_STATUS, 32'h0);
        // Code 0 means no limit at either extreme
        reg_write(`BVF_ADDR_SUPPLY_CFG, 32'h0000_0088);
        motor_supply = 10'h000;
        cyc(2);
        chk("no uv limit", sel_flag(1'b0), 32'h0);
        motor_supply = 10'h3ff;
        cyc(2);
        chk("no ov limit", sel_flag(1'b1), 32'h0);
        for (int c = 1; c < 8; c++) begin
            sweep(1'b0, c[2:0], c[0]);
            sweep(1'b1, c[2:0], ~c[0]);
        end
        latch(1'b0);
        latch(1'b1);
        // Every retry limit: allowed attempts recover, the next one latches for codes 1..7
        for (int c = 0; c < 8; c++) begin
            reg_write(`BVF_ADDR_SUPPLY_CFG, {29'h0, c[2:0]});
            pulse_clear();
            for (int a = 0; a < RETRY_N[c]; a++) begin
                retry_once(1'b0);
            end
            if (c != 0) begin
                retry_once(1'b1);
                pulse_clear();
                chk("retry clear", {31'h0, retry_fault_latched}, 32'h0);
            end
        end
        complete_run();
    end
endmodule : testbench
